// file: logic/debug_event_pin_logic.sv
// module: event input and event output pin logic of the on-chip debugger
// Operation
// RL1: code 01 makes falling input edge break
// RL2: equipment holds input low one clock
// RL3: input break sets external break flag
// RL4: code 01 pulses output low on entry
// RL5: code 10 shows enabled unit hits
// RL6: each unit has event-output enable bit
// RL7: input pin may request trace sync
// RL8: output pin may carry trace timing
// RL9: other input codes raise no break
`timescale 1ns/1ps
`default_nettype none

module debug_event_pin_logic
  import debug_event_pkg::*;
(
  input wire logic ref_clk, // 40 MHz cpu clock
  input wire logic reset, // synchronous, active high
  input wire debug_event_pkg::debug_control_reg_t debugControl, // control
  input wire debug_event_pkg::unit_control_t unitControl, // unit enables
  input wire logic [debug_event_pkg::UNIT_COUNT-1:0] unitHit, // unit hits
  input wire logic debugEntry, // pulse: cpu enters debug mode
  input wire logic clearStatus, // pulse: software clears status
  input wire logic traceTiming, // trace timing level
  input wire logic event_in_pin, // event input pin
  output logic breakRequest, // pulse: stop execution
  output logic traceSyncRequest, // pulse: emit trace sync message
  output debug_event_pkg::debug_status_reg_t debugStatus, // status
  output logic event_out_pin // event output pin, active low
);

  import debug_event_pkg::*;

  // ------------------------------------------------------------
  // input edge detection
  // ------------------------------------------------------------
  logic eventInPrev_r;
  logic eventInPrev_nxt;
  logic fallEdge;

  always_comb
  begin
    eventInPrev_nxt = event_in_pin;
  end

  // RL2: edge taken one clock after fall
  assign fallEdge = eventInPrev_r & ~event_in_pin;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      eventInPrev_r <= 1'b1;
    else
      eventInPrev_r <= eventInPrev_nxt;
  end

  // ------------------------------------------------------------
  // break, sync and status
  // ------------------------------------------------------------
  logic break_r;
  logic break_nxt;
  logic sync_r;
  logic sync_nxt;
  logic extBreak_r;
  logic extBreak_nxt;

  always_comb
  begin
    // RL1: break on falling edge
    // RL9: only break code qualifies
    break_nxt = fallEdge && (debugControl.eventInControl == EVT_IN_BREAK);
    // RL7: trace sync alternative
    sync_nxt = fallEdge && (debugControl.eventInControl == EVT_IN_SYNC);
    // RL3: set wins over clear
    extBreak_nxt = extBreak_r;
    if (clearStatus)
      extBreak_nxt = 1'b0;
    if (break_nxt)
      extBreak_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      break_r <= 1'b0;
      sync_r <= 1'b0;
      extBreak_r <= 1'b0;
    end
    else
    begin
      break_r <= break_nxt;
      sync_r <= sync_nxt;
      extBreak_r <= extBreak_nxt;
    end
  end

  assign breakRequest = break_r;
  assign traceSyncRequest = sync_r;
  assign debugStatus.externalBreakFlag = extBreak_r;

  // ------------------------------------------------------------
  // event output pin
  // ------------------------------------------------------------
  logic [UNIT_COUNT-1:0] gatedHit;
  logic evtOut_r;
  logic evtOut_nxt;

  // RL6: per-unit enable gates each hit
  genvar u;
  generate
    for (u = 0; u < UNIT_COUNT; u++)
    begin : g_unit
      assign gatedHit[u] = unitHit[u] & unitControl.eventOutEnable[u];
    end
  endgenerate

  always_comb
  begin
    evtOut_nxt = EVT_OUT_IDLE;
    unique case (debugControl.eventOutSelect)
      // RL4: one-clock low on entry
      EVT_OUT_DEBUG_ENTRY: evtOut_nxt = ~debugEntry;
      // RL5: enabled hit status, low active
      EVT_OUT_UNIT_HIT: evtOut_nxt = ~(|gatedHit);
      // RL8: trace timing alternative
      EVT_OUT_TRACE: evtOut_nxt = traceTiming;
      default: evtOut_nxt = EVT_OUT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      evtOut_r <= EVT_OUT_IDLE;
    else
      evtOut_r <= evtOut_nxt;
  end

  assign event_out_pin = evtOut_r;

endmodule : debug_event_pin_logic

`default_nettype wire

// file: logic/debug_event_pkg.sv
// package: constants and carrier types for the debug event pin logic
package debug_event_pkg;

  // event-in control field codes
  localparam logic [1:0] EVT_IN_BREAK = 2'h1;
  localparam logic [1:0] EVT_IN_SYNC = 2'h2;

  // event-out select field codes
  localparam logic [1:0] EVT_OUT_DEBUG_ENTRY = 2'h1;
  localparam logic [1:0] EVT_OUT_UNIT_HIT = 2'h2;
  localparam logic [1:0] EVT_OUT_TRACE = 2'h3;

  // number of breakpoint and watchpoint units
  localparam int UNIT_COUNT = 4;

  // idle level of the active-low event output pin
  localparam logic EVT_OUT_IDLE = 1'b1;

  // debug control fields driven by software
  typedef struct packed {
    logic [1:0] eventInControl;
    logic [1:0] eventOutSelect;
  } debug_control_reg_t;

  // per-unit control: event-output enable bit
  typedef struct packed {
    logic [UNIT_COUNT-1:0] eventOutEnable;
  } unit_control_t;

  // debug status visible to software
  typedef struct packed {
    logic externalBreakFlag;
  } debug_status_reg_t;

endpackage : debug_event_pkg

// file: test/debug_event_checker.sv
// checker: debug event pin relations
`timescale 1ns/1ps
`default_nettype none
module debug_event_checker import debug_event_pkg::*; (
  input wire logic ref_clk, reset, event_in_pin, debugEntry, // inputs
  input wire logic traceTiming, // trace timing level
  input wire debug_event_pkg::debug_status_reg_t debugStatus, // status
  input wire debug_event_pkg::debug_control_reg_t debugControl, // control
  input wire logic breakRequest, traceSyncRequest, event_out_pin // outputs
);
  wire logic [1:0] ic = debugControl.eventInControl;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_break_fall: assert property ($fell(event_in_pin) && ic == 2'h1
    |=> breakRequest) else $error("break missing");
  chk_break_refused: assert property (ic != 2'h1 |=> !breakRequest)
    else $error("stray break");
  chk_sync_fall: assert property ($fell(event_in_pin) && ic == 2'h2
    |=> traceSyncRequest) else $error("sync missing");
  chk_entry_pulse: assert property (debugControl.eventOutSelect == 2'h1
    |=> !event_out_pin == $past(debugEntry)) else $error("entry pin");
  chk_flag_set: assert property (breakRequest |-> debugStatus)
    else $error("flag missing");
  chk_trace_pin: assert property (debugControl.eventOutSelect == 2'h3
    |=> event_out_pin == $past(traceTiming)) else $error("trace pin");
endmodule : debug_event_checker
bind debug_event_pin_logic debug_event_checker chk_u (.ref_clk, .reset,
  .event_in_pin, .debugEntry, .debugControl, .breakRequest,
  .traceSyncRequest, .event_out_pin, .traceTiming, .debugStatus);
`default_nettype wire

// file: test/debug_event_pin_logic_test.sv
// bench: corner and random traffic for the debug event logic
`timescale 1ns/1ps
`default_nettype none
module debug_event_pin_logic_test;
  logic ref_clk = 1'b0, reset = 1'b1, prev = 1'b1, flag = 1'b0, e;
  logic [15:0] v = 16'h0;
  logic [15:0] corner [7] = '{16'h4001, 16'h4002, 16'h4000, 16'h8001,
    16'h8000, 16'h0001, 16'h0002};
  wire logic pin, brk, sync, st, o;
  int fail_count = 0, cmp_count = 0, n = 0;
  debug_event_pin_logic dut_u (.ref_clk, .reset, .debugControl(v[15:12]),
    .unitControl(v[11:8]), .unitHit(v[7:4]), .traceTiming(v[3]),
    .debugEntry(v[2]), .clearStatus(v[1]), .event_in_pin(pin),
    .breakRequest(brk), .traceSyncRequest(sync), .debugStatus(st),
    .event_out_pin(o));
  event_source src_u (.ref_clk, .fire(v[0]), .event_in_pin(pin));
  initial forever #12.5 ref_clk = ~ref_clk;
  function automatic logic exp_pin(input logic [15:0] x);
    return x[13] ? (x[12] ? x[3] : ~|(x[11:8] & x[7:4])) : !(x[12] & x[2]);
  endfunction : exp_pin
  task automatic check(input string s, input logic x, g);
    cmp_count++;
    fail_count += int'(g !== x);
    if (g !== x)
      $display("Error %s expected %b seen %b", s, x, g);
  endtask : check
  task automatic step(input logic [15:0] nv);
    v = nv;
    @(posedge ref_clk);
    e = prev & ~pin;
    prev = pin;
    flag = (e && v[15:14] == 2'h1) || (flag && !v[1]);
    #2;
    check("brk", e && v[15:14] == 2'h1, brk);
    check("sync", e && v[15:14] == 2'h2, sync);
    check("flag", flag, st);
    check("pin", exp_pin(v), o);
  endtask : step
  task automatic wrap_up(input int extra);
    fail_count += extra;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge ref_clk)
    if (n++ == 4000)
      wrap_up(1);
  initial
  begin
    void'($urandom(17910));
    repeat (2) @(posedge ref_clk);
    #2 reset = 1'b0;
    foreach (corner[i]) step(corner[i]);
    $display("corner test done");
    reset = 1'b1;
    @(posedge ref_clk);
    #2;
    check("rst brk", 1'b0, brk);
    check("rst flag", 1'b0, st);
    check("rst pin", 1'b1, o);
    reset = 1'b0;
    flag = 1'b0;
    prev = pin;
    $display("reset test done");
    repeat (3000) step(16'($urandom));
    $display("random test done");
    wrap_up(0);
  end
endmodule : debug_event_pin_logic_test
`default_nettype wire

// file: test/event_source.sv
// partner: equipment pulling the event input low
`timescale 1ns/1ps
`default_nettype none
module event_source (
  input wire logic ref_clk, fire, // clock, pull
  output logic event_in_pin // pin
);
  logic low_r = 1'b0;
  always_ff @(posedge ref_clk) low_r <= fire;
  assign event_in_pin = !low_r;
endmodule : event_source
`default_nettype wire
